// *** include/bdm_pkg.sv ***
// Constants and types shared by the banked data memory and its RAM.
// Notes on behaviour
// - Data memory is 32 banks of 128 bytes.
// - Bank layout: 12 core, 20 peripheral, up to 80 general, then shared RAM.
// - 16 shared bytes appear at the same offsets in every bank.
// - Direct accesses use the bank last written to bank_select.
// - Unimplemented locations read as zero.
// - Addresses are 12 bits: 5-bit bank above 7-bit offset.
// - Every location is reachable directly and through both indirect pointers.
// - Core registers decode identically at offsets 0 to 11 of every bank.
// - Peripheral registers occupy offsets 0x0c to 0x1f of every bank.
// - Add/subtract write zero, digit carry, carry from result; logic ops write zero; rotates write zero and carry.
// - Writes to timeout and power-down flags are ignored.
// - Status bits 7 to 5 always read zero.
// - Timeout flag set at power-up, watchdog clear, sleep; cleared by timeout.
// - Power-down flag set at power-up or watchdog clear; cleared by sleep.
// - Zero flag set when the operation result is zero, else cleared.
// - Digit carry set on carry out of result bit 3 for add/subtract.
// - Carry set on carry out of result bit 7 for add/subtract.
// - Subtract adds the two's complement; carries act as active-low borrows.
// - Rotates through carry load carry with the bit shifted out.
// - Indirect pointers reach general RAM as one linear region.
// - Pointer high bit 7 set makes indirect reads fetch program memory.
package bdm_pkg;
  localparam int ADDR_W    = 12;
  localparam int BANK_W    = 5;
  localparam int OFS_W     = 7;
  localparam int NUM_BANKS = 32;
  localparam int BANK_SIZE = 128;
  localparam int GPR_BANKS = 2;
  localparam int GPR_SIZE  = 80;
  localparam int SHR_SIZE  = 16;
  localparam int RAM_DEPTH = GPR_BANKS * GPR_SIZE + SHR_SIZE;
  localparam int RAM_AW    = 8;

  localparam logic [6:0] OFS_INDIRECT_DATA_0 = 7'h00;
  localparam logic [6:0] OFS_INDIRECT_DATA_1 = 7'h01;
  localparam logic [6:0] OFS_PCL   = 7'h02;
  localparam logic [6:0] OFS_STAT  = 7'h03;
  localparam logic [6:0] OFS_P0L   = 7'h04;
  localparam logic [6:0] OFS_P0H   = 7'h05;
  localparam logic [6:0] OFS_P1L   = 7'h06;
  localparam logic [6:0] OFS_P1H   = 7'h07;
  localparam logic [6:0] OFS_BSR   = 7'h08;
  localparam logic [6:0] OFS_WORKING_REGISTER  = 7'h09;
  localparam logic [6:0] OFS_PCLAT = 7'h0a;
  localparam logic [6:0] OFS_INTC  = 7'h0b;
  localparam logic [6:0] OFS_CORE_LAST = 7'h0b;
  localparam logic [6:0] OFS_PER_FIRST = 7'h0c;
  localparam logic [6:0] OFS_PER_LAST  = 7'h1f;
  localparam logic [6:0] OFS_GPR_FIRST = 7'h20;
  localparam logic [6:0] OFS_GPR_LAST  = 7'h6f;
  localparam logic [6:0] OFS_SHR_FIRST = 7'h70;

  localparam int ST_C  = 0;
  localparam int ST_DC = 1;
  localparam int ST_Z  = 2;
  localparam int ST_PD = 3;
  localparam int ST_TO = 4;
  localparam logic [7:0] STAT_IMPL_MASK = 8'h1f;
  localparam logic [7:0] STAT_RESET     = 8'h18;

  localparam logic [15:0] LIN_BASE = 16'h2000;
  localparam logic [15:0] LIN_LAST = 16'h209f;
  localparam int PTR_PROG_BIT = 15;

  typedef enum logic [3:0] {
    BDM_OP_NONE = 4'h0,
    BDM_OP_LOGIC = 4'h1,
    BDM_OP_ADD  = 4'h2,
    BDM_OP_SUB  = 4'h3,
    BDM_OP_RLC  = 4'h4,
    BDM_OP_RRC  = 4'h5
  } bdm_op_t;
endpackage

// *** design/bdm_ram.sv ***
// Single-port general and shared RAM with registered read data.
`timescale 1ns/1ps
module bdm_ram #(
  parameter int DEPTH = 176,
  parameter int AW    = 8
) (
  // Clock.
  input  wire logic          sys_clk,
  // Access.
  input  wire logic          wr_en,
  input  wire logic [AW-1:0] addr,
  input  wire logic [7:0]    wr_data,
  output logic      [7:0]    rd_data
);
  logic [7:0] mem [DEPTH];

  always_ff @(posedge sys_clk) begin
    if (wr_en) begin
      mem[addr] <= wr_data;
    end
  end

  always_ff @(posedge sys_clk) begin
    rd_data <= mem[addr];
  end
endmodule

// *** design/bdm_core.sv ***
// Banked data memory, core registers and arithmetic status flags.
`timescale 1ns/1ps
module bdm_core (
  // Clock and reset.
  input  wire logic                  sys_clk,
  input  wire logic                  reset,
  // File access from the execution unit.
  input  wire logic                  acc_en,
  input  wire logic                  acc_wr,
  input  wire logic                  acc_indirect,
  input  wire logic                  acc_ptr_sel,
  input  wire logic [6:0]            acc_ofs,
  input  wire logic [7:0]            acc_wdata,
  input  wire bdm_pkg::bdm_op_t      acc_op,
  // Arithmetic operands for flag generation.
  input  wire logic [7:0]            alu_a,
  input  wire logic [7:0]            alu_b,
  input  wire logic [7:0]            logic_result,
  // Special instruction events.
  input  wire logic                  watchdog_clear_instruction,
  input  wire logic                  sleep_instruction,
  input  wire logic                  watchdog_timeout,
  // Peripheral register window.
  input  wire logic [7:0]            per_rdata,
  output logic                       per_wr,
  output logic [11:0]                per_addr,
  output logic [7:0]                 per_wdata,
  // Program memory read port.
  input  wire logic [13:0]           prog_rdata,
  output logic [14:0]                prog_addr,
  // Results.
  output logic                       rd_valid,
  output logic [7:0]                 rd_data,
  output logic [7:0]                 alu_status,
  output logic [4:0]                 bank_select,
  output logic [7:0]                 working_register
);
  logic [7:0] pointer0_low, pointer0_high, pointer1_low, pointer1_high;
  logic [7:0] program_counter_low, pc_upper_latch, interrupt_control;
  logic [7:0] ram_rdata;
  logic [8:0] sum;
  logic [4:0] nib;
  logic [7:0] op_b;
  logic [7:0] result;
  logic [15:0] ptr;
  logic [11:0] addr;
  logic        is_ptr_prog, is_lin, next_ram_sel;
  logic        ram_sel, per_sel, prog_sel, zero_sel, core_sel;
  logic [7:0]  core_q;
  logic        ram_hit;
  logic [7:0]  ram_addr;
  logic        flag_op;

  function automatic logic [7:0] gpr_index(input logic [11:0] a);
    logic [4:0] bank;
    logic [6:0] ofs;
    bank = a[11:7];
    ofs  = a[6:0];
    if (ofs >= bdm_pkg::OFS_SHR_FIRST) begin
      gpr_index = 8'(bdm_pkg::GPR_BANKS * bdm_pkg::GPR_SIZE)
                + 8'(ofs - bdm_pkg::OFS_SHR_FIRST);
    end else begin
      gpr_index = 8'(bank * bdm_pkg::GPR_SIZE)
                + 8'(ofs - bdm_pkg::OFS_GPR_FIRST);
    end
  endfunction

  function automatic logic gpr_present(input logic [11:0] a);
    gpr_present = (a[6:0] >= bdm_pkg::OFS_SHR_FIRST) ||
      ((a[6:0] >= bdm_pkg::OFS_GPR_FIRST) &&
       (a[11:7] < 5'(bdm_pkg::GPR_BANKS)));
  endfunction

  // Address formation for direct and indirect accesses.
  always_comb begin
    ptr = acc_ptr_sel ? {pointer1_high, pointer1_low}
                      : {pointer0_high, pointer0_low};
    is_ptr_prog = acc_indirect && ptr[bdm_pkg::PTR_PROG_BIT];
    is_lin = acc_indirect && !is_ptr_prog &&
             (ptr >= bdm_pkg::LIN_BASE) && (ptr <= bdm_pkg::LIN_LAST);
    if (!acc_indirect) begin
      addr = {bank_select, acc_ofs};
    end else begin
      addr = ptr[11:0];
    end
    core_sel = !acc_indirect || (!is_lin && !is_ptr_prog &&
               ptr[15:12] == 4'h0);
    per_sel  = core_sel && addr[6:0] >= bdm_pkg::OFS_PER_FIRST &&
               addr[6:0] <= bdm_pkg::OFS_PER_LAST;
    ram_hit  = is_lin || (core_sel && gpr_present(addr));
    if (is_lin) begin
      ram_addr = 8'(ptr - bdm_pkg::LIN_BASE);
    end else begin
      ram_addr = gpr_index(addr);
    end
    next_ram_sel = ram_hit;
  end

  // Flag computation; subtract adds the two's complement.
  always_comb begin
    op_b = (acc_op == bdm_pkg::BDM_OP_SUB) ? ~alu_b : alu_b;
    sum  = 9'(alu_a) + 9'(op_b) +
           9'(acc_op == bdm_pkg::BDM_OP_SUB);
    nib  = 5'(alu_a[3:0]) + 5'(op_b[3:0]) +
           5'(acc_op == bdm_pkg::BDM_OP_SUB);
    case (acc_op)
      bdm_pkg::BDM_OP_ADD, bdm_pkg::BDM_OP_SUB: result = sum[7:0];
      bdm_pkg::BDM_OP_RLC: result = {alu_a[6:0], alu_status[0]};
      bdm_pkg::BDM_OP_RRC: result = {alu_status[0], alu_a[7:1]};
      default: result = logic_result;
    endcase
    flag_op = acc_en && acc_op != bdm_pkg::BDM_OP_NONE;
  end

  function automatic logic [7:0] core_read(input logic [6:0] o);
    case (o)
      bdm_pkg::OFS_PCL:   core_read = program_counter_low;
      bdm_pkg::OFS_STAT:  core_read = alu_status & bdm_pkg::STAT_IMPL_MASK;
      bdm_pkg::OFS_P0L:   core_read = pointer0_low;
      bdm_pkg::OFS_P0H:   core_read = pointer0_high;
      bdm_pkg::OFS_P1L:   core_read = pointer1_low;
      bdm_pkg::OFS_P1H:   core_read = pointer1_high;
      bdm_pkg::OFS_BSR:   core_read = {3'h0, bank_select};
      bdm_pkg::OFS_WORKING_REGISTER:  core_read = working_register;
      bdm_pkg::OFS_PCLAT: core_read = pc_upper_latch;
      bdm_pkg::OFS_INTC:  core_read = interrupt_control;
      default:            core_read = 8'h00;
    endcase
  endfunction

  logic core_hit;
  logic core_wr;
  assign core_hit = core_sel && addr[6:0] <= bdm_pkg::OFS_CORE_LAST;
  assign core_wr  = acc_en && acc_wr && core_hit;
  assign core_q   = core_read(addr[6:0]);

  // Core register writes, mirrored in every bank.
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      pointer0_low <= 8'h00;
      pointer0_high <= 8'h00;
      pointer1_low <= 8'h00;
      pointer1_high <= 8'h00;
      bank_select <= 5'h00;
      working_register <= 8'h00;
      program_counter_low <= 8'h00;
      pc_upper_latch <= 8'h00;
      interrupt_control <= 8'h00;
    end else if (core_wr) begin
      case (addr[6:0])
        bdm_pkg::OFS_PCL:   program_counter_low <= acc_wdata;
        bdm_pkg::OFS_P0L:   pointer0_low <= acc_wdata;
        bdm_pkg::OFS_P0H:   pointer0_high <= acc_wdata;
        bdm_pkg::OFS_P1L:   pointer1_low <= acc_wdata;
        bdm_pkg::OFS_P1H:   pointer1_high <= acc_wdata;
        bdm_pkg::OFS_BSR:   bank_select <= acc_wdata[4:0];
        bdm_pkg::OFS_WORKING_REGISTER:  working_register <= acc_wdata;
        bdm_pkg::OFS_PCLAT: pc_upper_latch <= acc_wdata;
        bdm_pkg::OFS_INTC:  interrupt_control <= acc_wdata;
        default: ;
      endcase
    end
  end

  // Status register: flags from logic win over data writes.
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      alu_status <= bdm_pkg::STAT_RESET;
    end else begin
      if (core_wr && addr[6:0] == bdm_pkg::OFS_STAT && !flag_op) begin
        alu_status[bdm_pkg::ST_Z]  <= acc_wdata[bdm_pkg::ST_Z];
        alu_status[bdm_pkg::ST_DC] <= acc_wdata[bdm_pkg::ST_DC];
        alu_status[bdm_pkg::ST_C]  <= acc_wdata[bdm_pkg::ST_C];
      end
      if (flag_op) begin
        alu_status[bdm_pkg::ST_Z] <= (result == 8'h00);
        case (acc_op)
          bdm_pkg::BDM_OP_ADD, bdm_pkg::BDM_OP_SUB: begin
            alu_status[bdm_pkg::ST_DC] <= nib[4];
            alu_status[bdm_pkg::ST_C]  <= sum[8];
          end
          bdm_pkg::BDM_OP_RLC: alu_status[bdm_pkg::ST_C] <= alu_a[7];
          bdm_pkg::BDM_OP_RRC: alu_status[bdm_pkg::ST_C] <= alu_a[0];
          default: ;
        endcase
      end
      if (watchdog_clear_instruction) begin
        alu_status[bdm_pkg::ST_TO] <= 1'b1;
        alu_status[bdm_pkg::ST_PD] <= 1'b1;
      end else if (sleep_instruction) begin
        alu_status[bdm_pkg::ST_TO] <= 1'b1;
        alu_status[bdm_pkg::ST_PD] <= 1'b0;
      end else if (watchdog_timeout) begin
        alu_status[bdm_pkg::ST_TO] <= 1'b0;
      end
      alu_status[7:5] <= 3'h0;
    end
  end

  bdm_ram #(
    .DEPTH (bdm_pkg::RAM_DEPTH),
    .AW    (bdm_pkg::RAM_AW)
  ) u_ram (
    .sys_clk (sys_clk),
    .wr_en   (acc_en && acc_wr && ram_hit),
    .addr    (ram_addr),
    .wr_data (acc_wdata),
    .rd_data (ram_rdata)
  );

  // Outbound peripheral and program memory requests.
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      per_wr <= 1'b0;
      per_addr <= 12'h000;
      per_wdata <= 8'h00;
      prog_addr <= 15'h0000;
    end else begin
      per_wr <= acc_en && acc_wr && per_sel;
      per_addr <= addr;
      per_wdata <= acc_wdata;
      prog_addr <= ptr[14:0];
    end
  end

  logic [7:0] core_q_r;
  // Read pipeline: one cycle from request to rd_valid.
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      rd_valid <= 1'b0;
      ram_sel <= 1'b0;
      prog_sel <= 1'b0;
      zero_sel <= 1'b0;
      core_q_r <= 8'h00;
    end else begin
      rd_valid <= acc_en && !acc_wr;
      ram_sel <= next_ram_sel;
      prog_sel <= is_ptr_prog;
      zero_sel <= !(next_ram_sel || is_ptr_prog || per_sel || core_hit);
      core_q_r <= core_hit ? core_q : 8'h00;
    end
  end

  logic per_sel_r;
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      per_sel_r <= 1'b0;
    end else begin
      per_sel_r <= per_sel;
    end
  end

  // Program and peripheral data arrive in the same cycle as their registered address.
  always_comb begin
    if (zero_sel) begin
      rd_data = 8'h00;
    end else if (prog_sel) begin
      rd_data = prog_rdata[7:0];
    end else if (ram_sel) begin
      rd_data = ram_rdata;
    end else if (per_sel_r) begin
      rd_data = per_rdata;
    end else begin
      rd_data = core_q_r;
    end
  end

  AST_STAT_HIGH_ZERO: assert property (@(posedge sys_clk) disable iff (reset)
    alu_status[7:5] == 3'h0) else $error("status upper bits set");
  AST_SLEEP_PD: assert property (@(posedge sys_clk) disable iff (reset)
    sleep_instruction && !watchdog_clear_instruction |=>
    !alu_status[3] && alu_status[4]) else $error("sleep flags");
  AST_WATCHDOG_CLEAR_INSTRUCTION: assert property (@(posedge sys_clk) disable iff (reset)
    watchdog_clear_instruction |=> alu_status[4] && alu_status[3])
    else $error("watchdog clear flags");
  AST_TIMEOUT: assert property (@(posedge sys_clk) disable iff (reset)
    watchdog_timeout && !watchdog_clear_instruction && !sleep_instruction
    |=> !alu_status[4]) else $error("timeout flag");
  AST_TO_PD_WRITE: assert property (@(posedge sys_clk) disable iff (reset)
    !watchdog_clear_instruction && !sleep_instruction && !watchdog_timeout
    |=> $stable(alu_status[4:3])) else $error("to/pd changed");
  AST_ZERO: assert property (@(posedge sys_clk) disable iff (reset)
    flag_op |=> alu_status[2] == $past(result == 8'h00))
    else $error("zero flag");
  AST_ADD_CARRY: assert property (@(posedge sys_clk) disable iff (reset)
    acc_en && acc_op == bdm_pkg::BDM_OP_ADD |=>
    alu_status[0] == $past(sum[8]) && alu_status[1] == $past(nib[4]))
    else $error("add carries");
  AST_BSR_DIRECT: assert property (@(posedge sys_clk) disable iff (reset)
    acc_en && !acc_indirect |-> addr == {bank_select, acc_ofs})
    else $error("direct address");
  AST_UNIMPL_ZERO: assert property (@(posedge sys_clk) disable iff (reset)
    zero_sel |-> rd_data == 8'h00) else $error("unimpl read");
endmodule

// *** dv/bdm_far_model.sv ***
// Far-side model: peripheral register bytes and program memory words.
`timescale 1ns/1ps
module bdm_far_model (
  // Clock.
  input  wire logic        sys_clk,
  // Peripheral window.
  input  wire logic        per_wr,
  input  wire logic [11:0] per_addr,
  input  wire logic [7:0]  per_wdata,
  output logic      [7:0]  per_rdata,
  // Program memory.
  input  wire logic [14:0] prog_addr,
  output logic      [13:0] prog_rdata
);
  logic [7:0]  per_mem [4096];
  logic [11:0] last_wr_addr = 12'h000;

  // Peripheral bytes start cleared and keep what the core last wrote.
  initial begin
    foreach (per_mem[i]) begin
      per_mem[i] = 8'h00;
    end
  end

  always @(posedge sys_clk) begin
    if (per_wr) begin
      per_mem[per_addr] <= per_wdata;
      last_wr_addr <= per_addr;
    end
  end

  assign per_rdata = per_mem[per_addr];
  // Each program word differs from its neighbours so a wrong address shows.
  assign prog_rdata = prog_addr[13:0] ^ 14'h15a3;
endmodule

// *** dv/tb.sv ***
// Self-checking bench for the banked data memory core.
`timescale 1ns/1ps
module tb;
  logic              sys_clk = 1'b0;
  logic              reset = 1'b1;
  logic              acc_en = 1'b0;
  logic              acc_wr = 1'b0;
  logic              acc_indirect = 1'b0;
  logic              acc_ptr_sel = 1'b0;
  logic [6:0]        acc_ofs = 7'h00;
  logic [7:0]        acc_wdata = 8'h00;
  bdm_pkg::bdm_op_t  acc_op = bdm_pkg::BDM_OP_NONE;
  logic [7:0]        alu_a = 8'h00;
  logic [7:0]        alu_b = 8'h00;
  logic [7:0]        logic_result = 8'h00;
  logic [2:0]        events = 3'h0;
  logic [7:0]        per_rdata;
  logic              per_wr;
  logic [11:0]       per_addr;
  logic [7:0]        per_wdata;
  logic [13:0]       prog_rdata;
  logic [14:0]       prog_addr;
  logic              rd_valid;
  logic [7:0]        rd_data;
  logic [7:0]        alu_status;
  logic [4:0]        bank_select;
  logic [7:0]        working_register;
  logic [7:0]        rd_q;
  logic              rv_q;
  int                mismatches = 0;
  int                check_count = 0;

  always #5 sys_clk = ~sys_clk;

  bdm_core dut_u (
    .sys_clk(sys_clk), .reset(reset), .acc_en(acc_en), .acc_wr(acc_wr),
    .acc_indirect(acc_indirect), .acc_ptr_sel(acc_ptr_sel),
    .acc_ofs(acc_ofs), .acc_wdata(acc_wdata), .acc_op(acc_op),
    .alu_a(alu_a), .alu_b(alu_b), .logic_result(logic_result),
    .watchdog_clear_instruction(events[2]),
    .sleep_instruction(events[1]), .watchdog_timeout(events[0]),
    .per_rdata(per_rdata), .per_wr(per_wr), .per_addr(per_addr),
    .per_wdata(per_wdata), .prog_rdata(prog_rdata), .prog_addr(prog_addr),
    .rd_valid(rd_valid), .rd_data(rd_data), .alu_status(alu_status),
    .bank_select(bank_select), .working_register(working_register)
  );

  bdm_far_model far_u (
    .sys_clk(sys_clk), .per_wr(per_wr), .per_addr(per_addr),
    .per_wdata(per_wdata), .per_rdata(per_rdata),
    .prog_addr(prog_addr), .prog_rdata(prog_rdata)
  );

  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    check_count++;
    if (got !== exp) begin
      mismatches++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // One access pulse; the answer is sampled in the cycle after the request.
  task automatic acc(input logic wr, input logic ind, input logic ps,
                     input logic [6:0] ofs, input logic [7:0] wd,
                     input bdm_pkg::bdm_op_t op);
    @(negedge sys_clk);
    acc_en = 1'b1;
    acc_wr = wr;
    acc_indirect = ind;
    acc_ptr_sel = ps;
    acc_ofs = ofs;
    acc_wdata = wd;
    acc_op = op;
    @(negedge sys_clk);
    acc_en = 1'b0;
    acc_op = bdm_pkg::BDM_OP_NONE;
    rd_q = rd_data;
    rv_q = rd_valid;
  endtask

  task automatic wr(input logic [6:0] ofs, input logic [7:0] wd);
    acc(1'b1, 1'b0, 1'b0, ofs, wd, bdm_pkg::BDM_OP_NONE);
  endtask

  task automatic rd(input logic ind, input logic ps, input logic [6:0] ofs,
                    input logic [7:0] exp);
    acc(1'b0, ind, ps, ofs, 8'h00, bdm_pkg::BDM_OP_NONE);
    check({15'h0, rv_q}, 16'h0001);
    check({8'h0, rd_q}, {8'h0, exp});
  endtask

  task automatic t_banks;
    wr(7'h08, 8'h01);
    wr(7'h20, 8'ha1);
    wr(7'h08, 8'h00);
    wr(7'h20, 8'ha0);
    rd(1'b0, 1'b0, 7'h20, 8'ha0);
    wr(7'h08, 8'h01);
    rd(1'b0, 1'b0, 7'h20, 8'ha1);
    wr(7'h70, 8'h5c);
    wr(7'h08, 8'h1f);
    check({11'h0, bank_select}, 16'h001f);
    rd(1'b0, 1'b0, 7'h70, 8'h5c);
    rd(1'b0, 1'b0, 7'h03, 8'h18);
    wr(7'h08, 8'h05);
    rd(1'b0, 1'b0, 7'h20, 8'h00);
    wr(7'h09, 8'h3c);
    check({8'h0, working_register}, 16'h003c);
  endtask

  task automatic t_periph;
    wr(7'h08, 8'h02);
    // The peripheral write pulse is registered, so the model stores it
    // one edge after the access; let that edge pass before looking.
    wr(7'h0c, 8'h77);
    @(negedge sys_clk);
    check({4'h0, far_u.last_wr_addr}, 16'h010c);
    wr(7'h1f, 8'h88);
    @(negedge sys_clk);
    check({4'h0, far_u.last_wr_addr}, 16'h011f);
    rd(1'b0, 1'b0, 7'h0c, 8'h77);
    rd(1'b0, 1'b0, 7'h1f, 8'h88);
  endtask

  task automatic t_status_wr;
    wr(7'h03, 8'hff);
    check({8'h0, alu_status}, 16'h001f);
    wr(7'h03, 8'h00);
    check({8'h0, alu_status}, 16'h0018);
  endtask

  task automatic op_case(input bdm_pkg::bdm_op_t op, input logic [7:0] a,
                         input logic [7:0] b, input logic [7:0] lr,
                         input logic [6:0] ofs);
    logic       sub;
    logic [7:0] bb;
    logic [8:0] s;
    logic [4:0] d;
    logic [7:0] e;
    logic [7:0] m;
    sub = (op == bdm_pkg::BDM_OP_SUB);
    bb = sub ? ~b : b;
    s = {1'b0, a} + {1'b0, bb} + {8'h0, sub};
    d = {1'b0, a[3:0]} + {1'b0, bb[3:0]} + {4'h0, sub};
    e = {5'h03, s[7:0] == 8'h00, d[4], s[8]};
    m = 8'hff;
    if (op == bdm_pkg::BDM_OP_RLC || op == bdm_pkg::BDM_OP_RRC) begin
      e[0] = (op == bdm_pkg::BDM_OP_RLC) ? a[7] : a[0];
      m = 8'h01;
    end
    if (op == bdm_pkg::BDM_OP_LOGIC) begin
      e[2] = (lr == 8'h00);
      m = 8'h04;
    end
    alu_a = a;
    alu_b = b;
    logic_result = lr;
    acc(1'b1, 1'b0, 1'b0, ofs, 8'hff, op);
    check({8'h0, alu_status & m}, {8'h0, e & m});
  endtask

  task automatic t_flags;
    op_case(bdm_pkg::BDM_OP_ADD, 8'h0f, 8'h01, 8'h00, 7'h21);
    op_case(bdm_pkg::BDM_OP_ADD, 8'hff, 8'h01, 8'h00, 7'h21);
    op_case(bdm_pkg::BDM_OP_SUB, 8'h05, 8'h05, 8'h00, 7'h21);
    op_case(bdm_pkg::BDM_OP_SUB, 8'h03, 8'h04, 8'h00, 7'h21);
    op_case(bdm_pkg::BDM_OP_SUB, 8'h20, 8'h01, 8'h00, 7'h21);
    op_case(bdm_pkg::BDM_OP_RLC, 8'h80, 8'h00, 8'h00, 7'h21);
    op_case(bdm_pkg::BDM_OP_RRC, 8'h80, 8'h00, 8'h00, 7'h21);
    op_case(bdm_pkg::BDM_OP_RRC, 8'h01, 8'h00, 8'h00, 7'h21);
    op_case(bdm_pkg::BDM_OP_LOGIC, 8'h00, 8'h00, 8'h00, 7'h21);
    op_case(bdm_pkg::BDM_OP_LOGIC, 8'h00, 8'h00, 8'h40, 7'h21);
    op_case(bdm_pkg::BDM_OP_ADD, 8'h10, 8'h20, 8'h00, 7'h03);
  endtask

  task automatic ev(input logic [2:0] e, input logic [1:0] exp);
    @(negedge sys_clk);
    events = e;
    @(negedge sys_clk);
    events = 3'h0;
    check({14'h0, alu_status[4:3]}, {14'h0, exp});
  endtask

  task automatic t_indirect;
    wr(7'h04, 8'h55);
    wr(7'h05, 8'h20);
    acc(1'b1, 1'b1, 1'b0, 7'h00, 8'hc3, bdm_pkg::BDM_OP_NONE);
    wr(7'h08, 8'h01);
    rd(1'b0, 1'b0, 7'h25, 8'hc3);
    wr(7'h06, 8'ha5);
    wr(7'h07, 8'h00);
    rd(1'b1, 1'b1, 7'h00, 8'hc3);
    wr(7'h07, 8'h80);
    wr(7'h06, 8'h12);
    rd(1'b1, 1'b1, 7'h00, 8'hb1);
  endtask

  task automatic conclude;
    if (mismatches == 0 && check_count > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  initial begin
    repeat (12) @(negedge sys_clk);
    reset = 1'b0;
    check({8'h0, alu_status}, 16'h0018);
    rd(1'b0, 1'b0, 7'h03, 8'h18);
    t_banks();
    t_periph();
    t_status_wr();
    t_flags();
    ev(3'b001, 2'b01);
    ev(3'b010, 2'b10);
    ev(3'b100, 2'b11);
    t_indirect();
    conclude();
  end

  // Cuts a hang short well after the sequence should have ended.
  initial begin
    #20000;
    mismatches++;
    conclude();
  end
endmodule
